/* File: rtl/flash_cfg_pkg.sv */
package flash_cfg_pkg;

    // Instruction codes seen on the command channel
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_ONE    = 8'h01;
    localparam logic [7:0] OP_WRITE_TWO    = 8'h31;
    localparam logic [7:0] OP_WRITE_THREE  = 8'h11;
    localparam logic [7:0] OP_SUSPEND      = 8'h75;
    localparam logic [7:0] OP_RESUME       = 8'h7A;
    localparam logic [7:0] OP_ENTER_QPI    = 8'h38;
    localparam logic [7:0] OP_EXIT_QPI     = 8'hFF;
    localparam logic [7:0] OP_ENTER_4B     = 8'hB7;
    localparam logic [7:0] OP_EXIT_4B      = 8'hE9;

    // Field positions inside status_config_two (S15..S8 on bits 7..0)
    localparam int SUS_BIT      = 7;
    localparam int CMP_BIT      = 6;
    localparam int OTP_LSB      = 3;
    localparam int QE_BIT       = 1;
    // Field positions inside status_config_three (S23..S16 on bits 7..0)
    localparam int ADS_BIT      = 0;
    localparam int ADP_BIT      = 1;
    localparam int WPS_BIT      = 2;
    localparam int DRV_LSB      = 5;
    localparam int HOLDRST_BIT  = 7;
    // Field positions inside the first status byte (protection bits only)
    localparam int TB_BIT       = 6;
    localparam int BP_LSB       = 2;

    // Reset values
    localparam logic       CMP_RESET     = 1'b0;
    localparam logic [2:0] OTP_RESET     = 3'h0;
    localparam logic       QE_RESET      = 1'b0;
    localparam logic       ADP_RESET     = 1'b0;
    localparam logic       WPS_RESET     = 1'b0;
    localparam logic [1:0] DRV_RESET     = 2'h2;
    localparam logic       HOLDRST_RESET = 1'b0;
    localparam logic       TB_RESET      = 1'b0;
    localparam logic [3:0] BP_RESET      = 4'h0;

    // Array geometry and protection codes
    localparam int          BLOCK_BITS  = 11;
    localparam logic [11:0] BLOCK_COUNT = 12'h800;
    localparam logic [3:0]  BP_ALL_CODE = 4'hC;

    typedef enum logic [1:0] {
        CHK_IDLE = 2'h0,
        CHK_EVAL = 2'h1,
        CHK_DONE = 2'h3
    } chk_state_t;

endpackage

/* File: rtl/cdc_handshake.sv */
`timescale 1ns/1ps
module cdc_handshake #(
    parameter int W = 16
) (
    input  wire logic         src_clk,
    input  wire logic         src_reset,
    input  wire logic         src_valid,
    input  wire logic [W-1:0] src_data,
    output logic              src_ready,
    input  wire logic         dst_clk,
    input  wire logic         dst_reset,
    output logic              dst_valid,
    output logic [W-1:0]      dst_data
);
    logic         req_ff, nxt_req;
    logic         src_ready_ff, nxt_src_ready;
    logic [W-1:0] hold_ff, nxt_hold;
    logic         ack_s1_ff, ack_s2_ff;
    logic         req_s1_ff, req_s2_ff;
    logic         ack_ff, nxt_ack;
    logic         dst_valid_ff, nxt_dst_valid;
    logic [W-1:0] dst_data_ff, nxt_dst_data;
    logic         accept;

    // Source side: word held stable until the far side has toggled back
    always_comb begin
        accept        = src_valid && src_ready_ff;
        nxt_req       = req_ff ^ accept;
        nxt_hold      = accept ? src_data : hold_ff;
        nxt_src_ready = !accept && (req_ff == ack_s2_ff);
    end

    always_ff @(posedge src_clk) begin
        if (src_reset) begin
            req_ff       <= 1'b0;
            hold_ff      <= '0;
            src_ready_ff <= 1'b0;
            ack_s1_ff    <= 1'b0;
            ack_s2_ff    <= 1'b0;
        end else begin
            req_ff       <= nxt_req;
            hold_ff      <= nxt_hold;
            src_ready_ff <= nxt_src_ready;
            ack_s1_ff    <= ack_ff;
            ack_s2_ff    <= ack_s1_ff;
        end
    end

    // Destination side: data is sampled only after the toggle has settled
    always_comb begin
        nxt_ack       = req_s2_ff;
        nxt_dst_valid = req_s2_ff != ack_ff;
        nxt_dst_data  = nxt_dst_valid ? hold_ff : dst_data_ff;
    end

    always_ff @(posedge dst_clk) begin
        if (dst_reset) begin
            req_s1_ff    <= 1'b0;
            req_s2_ff    <= 1'b0;
            ack_ff       <= 1'b0;
            dst_valid_ff <= 1'b0;
            dst_data_ff  <= '0;
        end else begin
            req_s1_ff    <= req_ff;
            req_s2_ff    <= req_s1_ff;
            ack_ff       <= nxt_ack;
            dst_valid_ff <= nxt_dst_valid;
            dst_data_ff  <= nxt_dst_data;
        end
    end

    assign src_ready = src_ready_ff;
    assign dst_valid = dst_valid_ff;
    assign dst_data  = dst_data_ff;
endmodule

/* File: rtl/flash_status_config_protect.sv */
`timescale 1ns/1ps
module flash_status_config_protect (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        link_clk,
    input  wire logic        link_reset,
    input  wire logic        link_cmd_valid,
    input  wire logic [7:0]  link_cmd_op,
    input  wire logic [7:0]  link_cmd_data,
    output logic             link_cmd_ready,
    output logic [7:0]       link_status_two,
    output logic [7:0]       link_status_three,
    input  wire logic        hold_rst_n_pin,
    input  wire logic        ibl_locked,
    input  wire logic        chk_valid,
    input  wire logic [10:0] chk_first_block,
    input  wire logic [10:0] chk_last_block,
    output logic             chk_done,
    output logic             chk_blocked,
    output logic             quad_enable,
    output logic             four_line_instruction_mode,
    output logic             current_addr_width,
    output logic             suspend_flag,
    output logic [2:0]       security_otp_locks,
    output logic [1:0]       drive_strength_field,
    output logic             wp_pin_active,
    output logic             hold_active,
    output logic             pin_reset_active,
    output logic             lock_preset,
    output logic             cmd_ignored
);
    localparam int BB = flash_cfg_pkg::BLOCK_BITS;

    // Protected-region decode, used once per check but kept apart for clarity
    function automatic logic prot_hit(input logic tb, input logic [3:0] bp, input logic cmp,
                                      input logic [BB-1:0] first, input logic [BB-1:0] last);
        logic [11:0]   n;
        logic [BB-1:0] lo;
        logic [BB-1:0] hi;
        logic          none;
        none = (bp == 4'h0);
        n    = 12'h001 << 4'(bp - 4'h1);
        if (bp >= flash_cfg_pkg::BP_ALL_CODE || none) begin
            lo = '0;
            hi = '1;
        end else if (tb) begin
            lo = '0;
            hi = BB'(n - 12'h001);
        end else begin
            lo = BB'(flash_cfg_pkg::BLOCK_COUNT - n);
            hi = '1;
        end
        // Inverted region protects everything outside lo..hi, and the whole array when bp is zero
        if (cmp)
            prot_hit = none || (first < lo) || (last > hi);
        else
            prot_hit = !none && (first <= hi) && (last >= lo);
    endfunction

    logic        cmd_fire;
    logic [15:0] cmd_word;
    logic [7:0]  op;
    logic [7:0]  dat;
    logic [7:0]  sr_two;
    logic [7:0]  sr_three;

    // Commands cross from the link clock as whole words
    cdc_handshake #(.W(16)) u_cmd_cdc (
        .src_clk   (link_clk),
        .src_reset (link_reset),
        .src_valid (link_cmd_valid),
        .src_data  ({link_cmd_op, link_cmd_data}),
        .src_ready (link_cmd_ready),
        .dst_clk   (ref_clk),
        .dst_reset (reset),
        .dst_valid (cmd_fire),
        .dst_data  (cmd_word)
    );

    // Status snapshot refreshed toward the link whenever the crossing is free
    cdc_handshake #(.W(16)) u_stat_cdc (
        .src_clk   (ref_clk),
        .src_reset (reset),
        .src_valid (1'b1),
        .src_data  ({sr_three, sr_two}),
        .src_ready (),
        .dst_clk   (link_clk),
        .dst_reset (link_reset),
        .dst_valid (),
        .dst_data  ({link_status_three, link_status_two})
    );

    logic hold_s1_ff, hold_s2_ff;
    logic sus_ff, nxt_sus;
    logic cmp_ff, nxt_cmp;
    logic [2:0] otp_ff, nxt_otp;
    logic qe_ff, nxt_qe;
    logic qpi_ff, nxt_qpi;
    logic ads_ff, nxt_ads;
    logic adp_ff, nxt_adp;
    logic wps_ff, nxt_wps;
    logic [1:0] drv_ff, nxt_drv;
    logic holdrst_ff, nxt_holdrst;
    logic tb_ff, nxt_tb;
    logic [3:0] bp_ff, nxt_bp;
    logic nv_arm_ff, nxt_nv_arm;
    logic hold_act_ff, nxt_hold_act;
    logic pin_rst_ff, nxt_pin_rst;
    logic preset_ff, nxt_preset;
    logic ignored_ff, nxt_ignored;
    logic wp_ff, nxt_wp;
    logic pin_rst_now;

    assign op  = cmd_word[15:8];
    assign dat = cmd_word[7:0];

    // Register image; unused positions read as zero
    assign sr_two   = {sus_ff, cmp_ff, otp_ff, 1'b0, qe_ff, 1'b0};
    assign sr_three = {holdrst_ff, drv_ff, 2'b00, wps_ff, adp_ff, ads_ff};

    // Shared pin is meaningful only in its selected role and only while quad is off
    assign pin_rst_now = !qe_ff && holdrst_ff && !hold_s2_ff;

    // Status and configuration next values
    always_comb begin
        nxt_sus      = sus_ff;
        nxt_cmp      = cmp_ff;
        nxt_otp      = otp_ff;
        nxt_qe       = qe_ff;
        nxt_qpi      = qpi_ff;
        nxt_ads      = ads_ff;
        nxt_adp      = adp_ff;
        nxt_wps      = wps_ff;
        nxt_drv      = drv_ff;
        nxt_holdrst  = holdrst_ff;
        nxt_tb       = tb_ff;
        nxt_bp       = bp_ff;
        nxt_nv_arm   = nv_arm_ff;
        nxt_ignored  = 1'b0;
        nxt_preset   = pin_rst_now;
        if (cmd_fire) begin
            nxt_nv_arm = (op == flash_cfg_pkg::OP_WRITE_ENABLE);
            case (op)
                flash_cfg_pkg::OP_SUSPEND: nxt_sus = 1'b1;
                flash_cfg_pkg::OP_RESUME:  nxt_sus = 1'b0;
                flash_cfg_pkg::OP_ENTER_QPI: begin
                    // Request dropped while quad lines are still disabled
                    nxt_qpi     = qe_ff || qpi_ff;
                    nxt_ignored = !qe_ff;
                end
                flash_cfg_pkg::OP_EXIT_QPI: nxt_qpi = 1'b0;
                flash_cfg_pkg::OP_ENTER_4B: nxt_ads = 1'b1;
                flash_cfg_pkg::OP_EXIT_4B:  nxt_ads = 1'b0;
                flash_cfg_pkg::OP_WRITE_ONE: begin
                    nxt_tb = dat[flash_cfg_pkg::TB_BIT];
                    nxt_bp = dat[flash_cfg_pkg::BP_LSB +: 4];
                end
                flash_cfg_pkg::OP_WRITE_TWO: begin
                    nxt_cmp = dat[flash_cfg_pkg::CMP_BIT];
                    nxt_otp = otp_ff | dat[flash_cfg_pkg::OTP_LSB +: 3];
                    nxt_qe  = qpi_ff | dat[flash_cfg_pkg::QE_BIT];
                end
                flash_cfg_pkg::OP_WRITE_THREE: begin
                    nxt_wps     = dat[flash_cfg_pkg::WPS_BIT];
                    nxt_drv     = dat[flash_cfg_pkg::DRV_LSB +: 2];
                    nxt_holdrst = dat[flash_cfg_pkg::HOLDRST_BIT];
                    if (nv_arm_ff)
                        nxt_adp = dat[flash_cfg_pkg::ADP_BIT];
                end
                default: nxt_ignored = 1'b0;
            endcase
        end
        // Device reset through the pin re-runs initialisation, non-volatile bits kept
        if (pin_rst_now) begin
            nxt_ads    = adp_ff;
            nxt_qpi    = 1'b0;
            nxt_nv_arm = 1'b0;
        end
        nxt_wp       = !nxt_qe;
        nxt_hold_act = !qe_ff && !holdrst_ff && !hold_s2_ff;
        nxt_pin_rst  = pin_rst_now;
    end

    // Reset stands for a power cycle: factory values everywhere
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hold_s1_ff  <= 1'b1;
            hold_s2_ff  <= 1'b1;
            sus_ff      <= 1'b0;
            cmp_ff      <= flash_cfg_pkg::CMP_RESET;
            otp_ff      <= flash_cfg_pkg::OTP_RESET;
            qe_ff       <= flash_cfg_pkg::QE_RESET;
            qpi_ff      <= 1'b0;
            ads_ff      <= flash_cfg_pkg::ADP_RESET;
            adp_ff      <= flash_cfg_pkg::ADP_RESET;
            wps_ff      <= flash_cfg_pkg::WPS_RESET;
            drv_ff      <= flash_cfg_pkg::DRV_RESET;
            holdrst_ff  <= flash_cfg_pkg::HOLDRST_RESET;
            tb_ff       <= flash_cfg_pkg::TB_RESET;
            bp_ff       <= flash_cfg_pkg::BP_RESET;
            nv_arm_ff   <= 1'b0;
            hold_act_ff <= 1'b0;
            pin_rst_ff  <= 1'b0;
            preset_ff   <= 1'b1;
            ignored_ff  <= 1'b0;
            wp_ff       <= !flash_cfg_pkg::QE_RESET;
        end else begin
            hold_s1_ff  <= hold_rst_n_pin;
            hold_s2_ff  <= hold_s1_ff;
            sus_ff      <= nxt_sus;
            cmp_ff      <= nxt_cmp;
            otp_ff      <= nxt_otp;
            qe_ff       <= nxt_qe;
            qpi_ff      <= nxt_qpi;
            ads_ff      <= nxt_ads;
            adp_ff      <= nxt_adp;
            wps_ff      <= nxt_wps;
            drv_ff      <= nxt_drv;
            holdrst_ff  <= nxt_holdrst;
            tb_ff       <= nxt_tb;
            bp_ff       <= nxt_bp;
            nv_arm_ff   <= nxt_nv_arm;
            hold_act_ff <= nxt_hold_act;
            pin_rst_ff  <= nxt_pin_rst;
            preset_ff   <= nxt_preset;
            ignored_ff  <= nxt_ignored;
            wp_ff       <= nxt_wp;
        end
    end

    flash_cfg_pkg::chk_state_t state_ff, nxt_state;
    logic [BB-1:0] first_ff, nxt_first;
    logic [BB-1:0] last_ff, nxt_last;
    logic          done_ff, nxt_done;
    logic          blocked_ff, nxt_blocked;

    // Region check: take, evaluate against the active scheme, answer once
    always_comb begin
        nxt_state   = state_ff;
        nxt_first   = first_ff;
        nxt_last    = last_ff;
        nxt_done    = 1'b0;
        nxt_blocked = blocked_ff;
        case (state_ff)
            flash_cfg_pkg::CHK_IDLE: begin
                if (chk_valid) begin
                    nxt_first = chk_first_block;
                    nxt_last  = chk_last_block;
                    nxt_state = flash_cfg_pkg::CHK_EVAL;
                end
            end
            flash_cfg_pkg::CHK_EVAL: begin
                nxt_done    = 1'b1;
                nxt_blocked = wps_ff ? ibl_locked
                                     : prot_hit(tb_ff, bp_ff, cmp_ff, first_ff, last_ff);
                nxt_state   = flash_cfg_pkg::CHK_DONE;
            end
            flash_cfg_pkg::CHK_DONE: nxt_state = flash_cfg_pkg::CHK_IDLE;
            default:                 nxt_state = flash_cfg_pkg::CHK_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_ff   <= flash_cfg_pkg::CHK_IDLE;
            first_ff   <= '0;
            last_ff    <= '0;
            done_ff    <= 1'b0;
            blocked_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            first_ff   <= nxt_first;
            last_ff    <= nxt_last;
            done_ff    <= nxt_done;
            blocked_ff <= nxt_blocked;
        end
    end

    assign chk_done                   = done_ff;
    assign chk_blocked                = blocked_ff;
    assign quad_enable                = qe_ff;
    assign four_line_instruction_mode = qpi_ff;
    assign current_addr_width         = ads_ff;
    assign suspend_flag               = sus_ff;
    assign security_otp_locks         = otp_ff;
    assign drive_strength_field       = drv_ff;
    assign wp_pin_active              = wp_ff;
    assign hold_active                = hold_act_ff;
    assign pin_reset_active           = pin_rst_ff;
    assign lock_preset                = preset_ff;
    assign cmd_ignored                = ignored_ff;

    sequence s_chk_req;
        chk_valid && state_ff == flash_cfg_pkg::CHK_IDLE;
    endsequence

    property p_suspend_set;
        @(posedge ref_clk) disable iff (reset) cmd_fire && op == flash_cfg_pkg::OP_SUSPEND |=> sus_ff;
    endproperty
    a_suspend_set: assert property (p_suspend_set) else $error("suspend flag not set");

    property p_suspend_clear;
        @(posedge ref_clk) disable iff (reset) cmd_fire && op == flash_cfg_pkg::OP_RESUME |=> !sus_ff;
    endproperty
    a_suspend_clear: assert property (p_suspend_clear) else $error("suspend flag not cleared");

    property p_otp_sticky;
        @(posedge ref_clk) disable iff (reset) 1'b1 |=> ((otp_ff & $past(otp_ff)) == $past(otp_ff));
    endproperty
    a_otp_sticky: assert property (p_otp_sticky) else $error("lock bit returned to zero");

    property p_qpi_gate;
        @(posedge ref_clk) disable iff (reset)
            cmd_fire && op == flash_cfg_pkg::OP_ENTER_QPI && !qe_ff && !qpi_ff |=> !qpi_ff && cmd_ignored;
    endproperty
    a_qpi_gate: assert property (p_qpi_gate) else $error("four-line mode entered without quad");

    property p_qe_held;
        @(posedge ref_clk) disable iff (reset) qpi_ff |-> qe_ff;
    endproperty
    a_qe_held: assert property (p_qe_held) else $error("quad enable cleared in four-line mode");

    property p_width_up;
        @(posedge ref_clk) disable iff (reset)
            cmd_fire && op == flash_cfg_pkg::OP_ENTER_4B && !pin_rst_now |=> current_addr_width;
    endproperty
    a_width_up: assert property (p_width_up) else $error("width not switched to four bytes");

    property p_adp_guard;
        @(posedge ref_clk) disable iff (reset)
            $changed(adp_ff) |-> $past(cmd_fire && nv_arm_ff && op == flash_cfg_pkg::OP_WRITE_THREE);
    endproperty
    a_adp_guard: assert property (p_adp_guard) else $error("power-up width changed without arming");

    property p_pin_init;
        @(posedge ref_clk) disable iff (reset) pin_rst_now |=> ads_ff == $past(adp_ff) && !qpi_ff && lock_preset;
    endproperty
    a_pin_init: assert property (p_pin_init) else $error("reset pin did not re-initialise");

    property p_quad_pin;
        @(posedge ref_clk) disable iff (reset) qe_ff ##1 qe_ff |-> !hold_active && !pin_reset_active;
    endproperty
    a_quad_pin: assert property (p_quad_pin) else $error("pin function active with quad on");

    property p_chk_answer;
        @(posedge ref_clk) disable iff (reset) s_chk_req |-> !chk_done ##1 !chk_done ##1 chk_done;
    endproperty
    a_chk_answer: assert property (p_chk_answer) else $error("region check answer late");

endmodule

/* File: testbench/host_link_model.sv */
`timescale 1ns/1ps
// Host controller model: one command word at a time on the link clock
module host_link_model (
    input  wire logic  link_clk,
    input  wire logic  link_cmd_ready,
    output logic       link_cmd_valid,
    output logic [7:0] link_cmd_op,
    output logic [7:0] link_cmd_data
);
    initial begin
        link_cmd_valid = 1'b0;
        link_cmd_op    = 8'h00;
        link_cmd_data  = 8'h00;
    end
    // Word held until taken; then wait for the ack so the core has applied it
    task automatic send(input logic [7:0] op, input logic [7:0] dat, output bit ok);
        int n;
        ok = 1'b0;
        @(posedge link_clk);
        link_cmd_valid <= 1'b1;
        link_cmd_op    <= op;
        link_cmd_data  <= dat;
        for (n = 0; n < 40 && !ok; n++) begin
            @(posedge link_clk);
            ok = (link_cmd_ready === 1'b1);
        end
        // Released lines show the inverse so a stale word never looks valid
        link_cmd_valid <= 1'b0;
        link_cmd_op    <= ~op;
        link_cmd_data  <= ~dat;
        for (n = 0; n < 40 && link_cmd_ready !== 1'b0; n++) @(posedge link_clk);
        for (n = 0; n < 40 && link_cmd_ready !== 1'b1; n++) @(posedge link_clk);
        ok = ok && (link_cmd_ready === 1'b1);
    endtask
endmodule

/* File: testbench/flash_status_config_protect_tb.sv */
`timescale 1ns/1ps
module flash_status_config_protect_tb;
    logic        ref_clk = 1'b0;
    logic        link_clk = 1'b0;
    logic        reset = 1'b1;
    logic        link_reset = 1'b1;
    logic        link_cmd_valid, link_cmd_ready, chk_done, chk_blocked;
    logic [7:0]  link_cmd_op, link_cmd_data, link_status_two, link_status_three;
    logic        hold_rst_n_pin = 1'b1;
    logic        ibl_locked = 1'b0;
    logic        chk_valid = 1'b0;
    logic [10:0] chk_first_block = 11'h000;
    logic [10:0] chk_last_block = 11'h000;
    logic        quad_enable, four_line_instruction_mode, current_addr_width, suspend_flag;
    logic        wp_pin_active, hold_active, pin_reset_active, lock_preset, cmd_ignored;
    logic [2:0]  security_otp_locks;
    logic [1:0]  drive_strength_field;
    int          n_fail = 0;
    int          checks_done = 0;
    bit          ok;
    logic        ign_seen = 1'b0;

    // One-cycle refusal pulse is caught here so a later compare can see it
    always @(posedge ref_clk) if (cmd_ignored === 1'b1) ign_seen <= 1'b1;

    // Periods chosen so the two clocks' rising edges never coincide
    always #10 ref_clk = ~ref_clk;
    always #16 link_clk = ~link_clk;

    flash_status_config_protect uut (.ref_clk, .reset, .link_clk, .link_reset, .link_cmd_valid,
        .link_cmd_op, .link_cmd_data, .link_cmd_ready, .link_status_two, .link_status_three,
        .hold_rst_n_pin, .ibl_locked, .chk_valid, .chk_first_block, .chk_last_block, .chk_done,
        .chk_blocked, .quad_enable, .four_line_instruction_mode, .current_addr_width, .suspend_flag,
        .security_otp_locks, .drive_strength_field, .wp_pin_active, .hold_active, .pin_reset_active,
        .lock_preset, .cmd_ignored);

    host_link_model host (.link_clk, .link_cmd_ready, .link_cmd_valid, .link_cmd_op, .link_cmd_data);

    task automatic test_done;
        $display("Checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk1(input string nm, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %b seen %b", nm, exp, got);
        end
    endtask

    task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // A lost command ends the run at once
    task automatic cmd(input logic [7:0] op, input logic [7:0] dat);
        host.send(op, dat, ok);
        if (!ok) begin
            n_fail++;
            test_done;
        end
        cyc(16);
    endtask

    // Valid drops at the taking edge so the idle block never sees a retry
    task automatic region(input logic [10:0] f, input logic [10:0] l, input logic exp);
        int n;
        @(posedge ref_clk);
        chk_valid       <= 1'b1;
        chk_first_block <= f;
        chk_last_block  <= l;
        @(posedge ref_clk);
        chk_valid <= 1'b0;
        for (n = 0; n < 4 && chk_done !== 1'b1; n++) cyc(1);
        chk1("chk_done", 1'b1, chk_done);
        chk1("chk_blocked", exp, chk_blocked);
    endtask

    task automatic prot(input logic tb, input logic [3:0] code, input logic [10:0] f, input logic [10:0] l,
                        input logic exp);
        cmd(8'h01, {1'b0, tb, code, 2'b00});
        region(f, l, exp);
    endtask

    initial begin
        cyc(8);
        chk1("lock_preset", 1'b1, lock_preset);
        reset      <= 1'b0;
        link_reset <= 1'b0;
        cyc(12);
        chk8("drive_strength_field", 8'h02, {6'h00, drive_strength_field});
        chk1("quad_enable", 1'b0, quad_enable);
        chk1("wp_pin_active", 1'b1, wp_pin_active);
        chk8("security_otp_locks", 8'h00, {5'h00, security_otp_locks});
        chk1("current_addr_width", 1'b0, current_addr_width);
        region(11'h000, 11'h7FF, 1'b0);
        cmd(8'h75, 8'h00);
        chk1("suspend_flag", 1'b1, suspend_flag);
        cmd(8'h7A, 8'h00);
        chk1("suspend_flag", 1'b0, suspend_flag);
        cmd(8'h38, 8'h00);
        chk1("four_line_instruction_mode", 1'b0, four_line_instruction_mode);
        chk1("cmd_ignored", 1'b1, ign_seen);
        cmd(8'h31, 8'h0A);
        chk8("link_status_two", 8'h0A, link_status_two);
        chk1("wp_pin_active", 1'b0, wp_pin_active);
        cmd(8'h38, 8'h00);
        chk1("four_line_instruction_mode", 1'b1, four_line_instruction_mode);
        cmd(8'h31, 8'h05);
        chk1("quad_enable", 1'b1, quad_enable);
        chk8("link_status_two", 8'h0A, link_status_two);
        cmd(8'hFF, 8'h00);
        cmd(8'h31, 8'h40);
        chk8("link_status_two", 8'h48, link_status_two);
        prot(1'b0, 4'h1, 11'h7FF, 11'h7FF, 1'b0);
        prot(1'b0, 4'h1, 11'h7FE, 11'h7FE, 1'b1);
        cmd(8'h31, 8'h00);
        prot(1'b0, 4'h1, 11'h7FF, 11'h7FF, 1'b1);
        region(11'h7FE, 11'h7FE, 1'b0);
        region(11'h7D0, 11'h7FF, 1'b1);
        prot(1'b1, 4'h1, 11'h000, 11'h000, 1'b1);
        region(11'h001, 11'h001, 1'b0);
        prot(1'b0, 4'hB, 11'h400, 11'h400, 1'b1);
        region(11'h3FF, 11'h3FF, 1'b0);
        prot(1'b1, 4'hB, 11'h3FF, 11'h3FF, 1'b1);
        region(11'h400, 11'h400, 1'b0);
        prot(1'b0, 4'hC, 11'h000, 11'h000, 1'b1);
        prot(1'b0, 4'h0, 11'h000, 11'h7FF, 1'b0);
        prot(1'b1, 4'hF, 11'h005, 11'h005, 1'b1);
        hold_rst_n_pin <= 1'b0;
        cyc(5);
        chk1("hold_active", 1'b1, hold_active);
        hold_rst_n_pin <= 1'b1;
        cmd(8'h31, 8'h02);
        hold_rst_n_pin <= 1'b0;
        cyc(5);
        chk1("hold_active", 1'b0, hold_active);
        hold_rst_n_pin <= 1'b1;
        cmd(8'h31, 8'h00);
        cmd(8'hB7, 8'h00);
        chk1("current_addr_width", 1'b1, current_addr_width);
        chk1("link_status_three", 1'b1, link_status_three[0]);
        cmd(8'hE9, 8'h00);
        chk1("current_addr_width", 1'b0, current_addr_width);
        for (int d = 0; d < 4; d++) begin
            cmd(8'h11, {1'b0, 2'(d), 5'b11000});
            chk8("link_status_three", {1'b0, 2'(d), 5'h00}, link_status_three);
        end
        cmd(8'h11, 8'hC2);
        chk8("link_status_three", 8'hC0, link_status_three);
        cmd(8'h06, 8'h00);
        cmd(8'h11, 8'hC2);
        chk8("link_status_three", 8'hC2, link_status_three);
        hold_rst_n_pin <= 1'b0;
        cyc(5);
        chk1("pin_reset_active", 1'b1, pin_reset_active);
        chk1("lock_preset", 1'b1, lock_preset);
        hold_rst_n_pin <= 1'b1;
        cyc(10);
        chk1("current_addr_width", 1'b1, current_addr_width);
        cmd(8'h11, 8'h44);
        ibl_locked <= 1'b1;
        region(11'h000, 11'h000, 1'b1);
        ibl_locked <= 1'b0;
        region(11'h000, 11'h000, 1'b0);
        test_done;
    end
endmodule
